// file: shared/ccd_pkg.sv
// ccd_pkg: constants shared by the instruction executor and its watchdog
// assumes a 32-bit apb bus with byte addresses on an 8-bit paddr
package ccd_pkg;

	// apb register byte offsets
	localparam logic [7:0] OFF_OPCODE = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_WREG   = 8'h08;
	localparam logic [7:0] OFF_PC     = 8'h0C;
	localparam logic [7:0] OFF_PCLAT  = 8'h10;
	localparam logic [7:0] OFF_TOS    = 8'h14;
	localparam logic [7:0] OFF_FADDR  = 8'h18;
	localparam logic [7:0] OFF_FDATA  = 8'h1C;
	localparam logic [7:0] OFF_WDOG   = 8'h20;
	localparam logic [7:0] OFF_LAST   = 8'h20;

	// register index is offset bits 5:2; all ones marks an unmapped address
	localparam logic [3:0] IDX_NONE = 4'hF;

	// opcode register fields
	localparam int unsigned OPC_OP_LSB = 0;
	localparam int unsigned OPC_OP_MSB = 2;
	localparam int unsigned OPC_D_BIT  = 3;
	localparam int unsigned OPC_F_LSB  = 4;
	localparam int unsigned OPC_F_MSB  = 10;

	// operation codes
	localparam logic [2:0] OP_NOP    = 3'h0;
	localparam logic [2:0] OP_WDCLR  = 3'h1;
	localparam logic [2:0] OP_CALL_VIA_WORKING_REG_OP  = 3'h2;
	localparam logic [2:0] OP_COMPLEMENT_FILE_OP   = 3'h3;
	localparam logic [2:0] OP_CLEAR_FILE_OP   = 3'h4;
	localparam logic [2:0] OP_DECREMENT_FILE_OP   = 3'h5;
	localparam logic [2:0] OP_CLEAR_WORKING_REG_OP   = 3'h6;
	localparam logic [2:0] OP_DECREMENT_SKIP_ON_ZERO_OP = 3'h7;

	// status register bit positions
	localparam int unsigned STS_Z    = 0;
	localparam int unsigned STS_TO_N = 1;
	localparam int unsigned STS_PD_N = 2;
	localparam int unsigned STS_BUSY = 3;
	localparam int unsigned STS_SKIP = 4;

	// tos register depth field
	localparam int unsigned TOS_SP_LSB = 16;

	// reset values
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [14:0] RST_PC     = 15'h0000;
	localparam logic [6:0]  RST_7BIT   = 7'h00;
	localparam logic [3:0]  RST_SP     = 4'h0;
	localparam logic        RST_FLAG_N = 1'b1;

	// timing: clocks per instruction cycle and watchdog prescale
	localparam logic [1:0]  CYC_LAST     = 2'h3;
	localparam logic [7:0]  WDT_PRE_LAST = 8'h03;
	localparam logic [7:0]  WDT_CNT_LAST = 8'hFF;
	localparam int unsigned STACK_DEPTH  = 16;

	typedef enum logic [0:0] {
		S_IDLE,
		S_CALL2
	} ccd_state_type;

endpackage

// file: shared/ccd_wdt_if.sv
// ccd_wdt_if: control and state between the executor and its watchdog
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface ccd_wdt_if;
	logic       clear;
	logic       tick;
	logic [7:0] count;
	logic [7:0] prescale;
	logic       timeout;

	modport ctrl (
		output clear,
		output tick,
		input  count,
		input  prescale,
		input  timeout
	);

	modport wdog (
		input  clear,
		input  tick,
		output count,
		output prescale,
		output timeout
	);
endinterface

// file: logic/ccd_wdog.sv
// ccd_wdog: watchdog counter with its prescaler
// assumes tick is a one-cycle pulse once per instruction cycle
`timescale 1ns/1ps
module ccd_wdog (
	input wire logic  mclk_i,
	input wire logic  nrst_i,
	ccd_wdt_if.wdog   wd
);
	logic [7:0] pre_reg;
	logic [7:0] cnt_reg;
	logic       tmo_reg;

	// clear zeroes prescaler and counter in the same step
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_reg <= ccd_pkg::RST_BYTE;
			cnt_reg <= ccd_pkg::RST_BYTE;
			tmo_reg <= 1'b0;
		end else if (wd.clear) begin
			pre_reg <= ccd_pkg::RST_BYTE;
			cnt_reg <= ccd_pkg::RST_BYTE;
			tmo_reg <= 1'b0;
		end else begin
			tmo_reg <= 1'b0;
			if (wd.tick) begin
				pre_reg <= (pre_reg == ccd_pkg::WDT_PRE_LAST) ? ccd_pkg::RST_BYTE
					: pre_reg + 8'h01;
				if (pre_reg == ccd_pkg::WDT_PRE_LAST) begin
					cnt_reg <= cnt_reg + 8'h01;
					tmo_reg <= (cnt_reg == ccd_pkg::WDT_CNT_LAST);
				end
			end
		end
	end

	assign wd.count    = cnt_reg;
	assign wd.prescale = pre_reg;
	assign wd.timeout  = tmo_reg;

	property p_clr_pre;
		@(posedge mclk_i) disable iff (!nrst_i)
		wd.clear |=> (pre_reg == 8'h00) && (cnt_reg == 8'h00) && !tmo_reg;
	endproperty
	a_clr_pre: assert property (p_clr_pre)
		else $error("watchdog prescaler not cleared with counter");
endmodule

// file: logic/ccd_core.sv
// ccd_core: executor for watchdog clear, call through w, complement,
// clear and decrement operations on a 128-byte file, with apb access
// assumes apb master on mclk_i; instructions are issued by opcode writes
`timescale 1ns/1ps
// Behaviour
// - watchdog clear zeroes counter, sets both flags
// - watchdog clear also zeroes the prescaler
// - call through w pushes pc plus one
// - pc gets latch bits high, w low
// - call through w lasts two instruction cycles
// - complement yields inverse of file register
// - destination bit zero to w, one to file
// - clear file writes zero, sets zero flag
// - decrement file subtracts one, routes by destination
// - clear w writes zero, sets zero flag
// - decrement skip routes result, flags untouched
// - nonzero decrement skip runs next normally
// - skip replaces next with no-operation cycle
module ccd_core (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	// map a byte address onto a register index
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		if (a[1:0] != 2'h0 || a > ccd_pkg::OFF_LAST) begin
			return ccd_pkg::IDX_NONE;
		end
		return a[5:2];
	endfunction

	ccd_wdt_if wd_bus ();

	ccd_pkg::ccd_state_type state_reg;
	logic [1:0]  div_reg;
	logic        cyc_en;
	logic        pend_reg;
	logic [2:0]  op_reg;
	logic        d_reg;
	logic [6:0]  f_reg;
	logic        skip_reg;
	logic [7:0]  w_reg;
	logic [14:0] pc_reg;
	logic [6:0]  latch_reg;
	logic [6:0]  faddr_reg;
	logic [3:0]  sp_reg;
	logic        z_reg;
	logic        to_n_reg;
	logic        pd_n_reg;
	logic [7:0]  file_mem [128];
	logic [14:0] stk_mem [ccd_pkg::STACK_DEPTH];
	logic [14:0] top_of_stack;
	logic        exec_go;
	logic        do_op;
	logic        busy;
	logic [7:0]  f_val;
	logic [7:0]  alu_res;
	logic        wr_file;
	logic        wr_w;
	logic        z_upd;
	logic        acc;
	logic        wr_en;
	logic [3:0]  wsel;
	logic        issue;
	logic [31:0] rd_val;

	// instruction-cycle enable: one pulse every four clocks
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	assign cyc_en = (div_reg == ccd_pkg::CYC_LAST);

	// apb decode; an opcode write while busy is held with wait states
	assign acc       = psel_i && penable_i;
	assign wsel      = reg_index(paddr_i);
	assign busy      = pend_reg || (state_reg != ccd_pkg::S_IDLE);
	assign pready_o  = !(acc && pwrite_i && (wsel == ccd_pkg::OFF_OPCODE[5:2]) && busy);
	assign pslverr_o = acc && pready_o && (wsel == ccd_pkg::IDX_NONE);
	assign wr_en     = acc && pwrite_i && pready_o;
	assign issue     = wr_en && (wsel == ccd_pkg::OFF_OPCODE[5:2]);

	// issued instruction waits for the next instruction-cycle boundary
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend_reg <= 1'b0;
			op_reg   <= ccd_pkg::OP_NOP;
			d_reg    <= 1'b0;
			f_reg    <= ccd_pkg::RST_7BIT;
		end else if (issue) begin
			pend_reg <= 1'b1;
			op_reg   <= pwdata_i[ccd_pkg::OPC_OP_MSB:ccd_pkg::OPC_OP_LSB];
			d_reg    <= pwdata_i[ccd_pkg::OPC_D_BIT];
			f_reg    <= pwdata_i[ccd_pkg::OPC_F_MSB:ccd_pkg::OPC_F_LSB];
		end else if (exec_go) begin
			pend_reg <= 1'b0;
		end
	end

	// a pending skip turns the instruction into a no-operation
	assign exec_go = (state_reg == ccd_pkg::S_IDLE) && pend_reg && cyc_en;
	assign do_op   = exec_go && !skip_reg;

	// sequencer: call through w holds a second instruction cycle
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= ccd_pkg::S_IDLE;
		end else begin
			unique case (state_reg)
				ccd_pkg::S_IDLE: begin
					if (do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP) begin
						state_reg <= ccd_pkg::S_CALL2;
					end
				end
				ccd_pkg::S_CALL2: begin
					if (cyc_en) begin
						state_reg <= ccd_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

	// result and destination of the file and w operations
	always_comb begin
		f_val   = file_mem[f_reg];
		alu_res = 8'h00;
		wr_file = 1'b0;
		wr_w    = 1'b0;
		z_upd   = 1'b0;
		unique case (op_reg)
			ccd_pkg::OP_COMPLEMENT_FILE_OP: begin
				alu_res = ~f_val;
				wr_w    = !d_reg;
				wr_file = d_reg;
				z_upd   = 1'b1;
			end
			ccd_pkg::OP_CLEAR_FILE_OP: begin
				wr_file = 1'b1;
				z_upd   = 1'b1;
			end
			ccd_pkg::OP_DECREMENT_FILE_OP, ccd_pkg::OP_DECREMENT_SKIP_ON_ZERO_OP: begin
				alu_res = f_val - 8'h01;
				wr_w    = !d_reg;
				wr_file = d_reg;
				z_upd   = (op_reg == ccd_pkg::OP_DECREMENT_FILE_OP);
			end
			ccd_pkg::OP_CLEAR_WORKING_REG_OP: begin
				wr_w  = 1'b1;
				z_upd = 1'b1;
			end
			ccd_pkg::OP_NOP, ccd_pkg::OP_WDCLR, ccd_pkg::OP_CALL_VIA_WORKING_REG_OP: begin
			end
		endcase
	end

	// skip flag: set by a zero decrement-skip result, used up when the next instruction executes
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			skip_reg <= 1'b0;
		end else if (do_op && op_reg == ccd_pkg::OP_DECREMENT_SKIP_ON_ZERO_OP) begin
			skip_reg <= (alu_res == 8'h00);
		end else if (exec_go) begin
			skip_reg <= 1'b0;
		end
	end

	// working register; executed results win over a same-cycle bus write
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_reg <= ccd_pkg::RST_BYTE;
		end else if (do_op && wr_w) begin
			w_reg <= alu_res;
		end else if (wr_en && wsel == ccd_pkg::OFF_WREG[5:2]) begin
			w_reg <= pwdata_i[7:0];
		end
	end

	// file registers are plain memory with no reset
	always_ff @(posedge mclk_i) begin
		if (do_op && wr_file) begin
			file_mem[f_reg] <= alu_res;
		end else if (wr_en && wsel == ccd_pkg::OFF_FDATA[5:2]) begin
			file_mem[faddr_reg] <= pwdata_i[7:0];
		end
	end

	// program counter: every issued cycle advances, call through w jumps
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc_reg <= ccd_pkg::RST_PC;
		end else if (do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP) begin
			pc_reg <= {latch_reg, w_reg};
		end else if (exec_go) begin
			pc_reg <= pc_reg + 15'h0001;
		end else if (wr_en && wsel == ccd_pkg::OFF_PC[5:2]) begin
			pc_reg <= pwdata_i[14:0];
		end
	end

	// software-loaded latch and file window address
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latch_reg <= ccd_pkg::RST_7BIT;
			faddr_reg <= ccd_pkg::RST_7BIT;
		end else if (wr_en) begin
			if (wsel == ccd_pkg::OFF_PCLAT[5:2]) begin
				latch_reg <= pwdata_i[6:0];
			end
			if (wsel == ccd_pkg::OFF_FADDR[5:2]) begin
				faddr_reg <= pwdata_i[6:0];
			end
		end
	end

	// return stack pointer; overflow simply wraps
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sp_reg <= ccd_pkg::RST_SP;
		end else if (do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP) begin
			sp_reg <= sp_reg + 4'h1;
		end
	end

	// one flop group per stack entry
	for (genvar gi = 0; gi < ccd_pkg::STACK_DEPTH; gi++) begin : g_stk
		always_ff @(posedge mclk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				stk_mem[gi] <= ccd_pkg::RST_PC;
			end else if (do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP && sp_reg == 4'(gi)) begin
				stk_mem[gi] <= pc_reg + 15'h0001;
			end
		end
	end
	assign top_of_stack = stk_mem[sp_reg - 4'h1];

	// zero flag; call and decrement-skip leave it alone
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			z_reg <= 1'b0;
		end else if (do_op && z_upd) begin
			z_reg <= (alu_res == 8'h00);
		end
	end

	// active-low flags; a timeout in the clear cycle still wins
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			to_n_reg <= ccd_pkg::RST_FLAG_N;
			pd_n_reg <= ccd_pkg::RST_FLAG_N;
		end else begin
			if (wd_bus.timeout) begin
				to_n_reg <= 1'b0;
			end else if (do_op && op_reg == ccd_pkg::OP_WDCLR) begin
				to_n_reg <= 1'b1;
			end
			if (do_op && op_reg == ccd_pkg::OP_WDCLR) begin
				pd_n_reg <= 1'b1;
			end
		end
	end

	// watchdog runs on instruction cycles and is cleared by the executor
	assign wd_bus.clear = do_op && (op_reg == ccd_pkg::OP_WDCLR);
	assign wd_bus.tick  = cyc_en;

	ccd_wdog u_wdog (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.wd     (wd_bus)
	);

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (reg_index(paddr_i))
			ccd_pkg::OFF_OPCODE[5:2]: rd_val[10:0] = {f_reg, d_reg, op_reg};
			ccd_pkg::OFF_STATUS[5:2]: begin
				rd_val[ccd_pkg::STS_Z]    = z_reg;
				rd_val[ccd_pkg::STS_TO_N] = to_n_reg;
				rd_val[ccd_pkg::STS_PD_N] = pd_n_reg;
				rd_val[ccd_pkg::STS_BUSY] = busy;
				rd_val[ccd_pkg::STS_SKIP] = skip_reg;
			end
			ccd_pkg::OFF_WREG[5:2]:   rd_val[7:0] = w_reg;
			ccd_pkg::OFF_PC[5:2]:     rd_val[14:0] = pc_reg;
			ccd_pkg::OFF_PCLAT[5:2]:  rd_val[6:0] = latch_reg;
			ccd_pkg::OFF_TOS[5:2]: begin
				rd_val[14:0] = top_of_stack;
				rd_val[ccd_pkg::TOS_SP_LSB +: 4] = sp_reg;
			end
			ccd_pkg::OFF_FADDR[5:2]:  rd_val[6:0] = faddr_reg;
			ccd_pkg::OFF_FDATA[5:2]:  rd_val[7:0] = file_mem[faddr_reg];
			ccd_pkg::OFF_WDOG[5:2]:   rd_val[15:0] = {wd_bus.prescale, wd_bus.count};
			default:                  rd_val = 32'h0000_0000;
		endcase
	end

	// read data is caught in the setup cycle so prdata is a flop output
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= rd_val;
		end
	end

	property p_wdclr;
		(do_op && op_reg == ccd_pkg::OP_WDCLR) |=>
			(wd_bus.count == 8'h00) && pd_n_reg && (to_n_reg || $past(wd_bus.timeout));
	endproperty
	a_wdclr: assert property (p_wdclr)
		else $error("watchdog clear did not zero counter or set flags");

	property p_push;
		(do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP) |=>
			(top_of_stack == $past(pc_reg) + 15'h0001) && (sp_reg == $past(sp_reg) + 4'h1);
	endproperty
	a_push: assert property (p_push)
		else $error("call did not push return address");

	property p_callpc;
		(do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP) |=>
			(pc_reg == {$past(latch_reg), $past(w_reg)}) && (z_reg == $past(z_reg));
	endproperty
	a_callpc: assert property (p_callpc)
		else $error("call target or flags wrong");

	property p_call2;
		(do_op && op_reg == ccd_pkg::OP_CALL_VIA_WORKING_REG_OP) |=>
			(busy && state_reg == ccd_pkg::S_CALL2) [*4] ##1 (state_reg == ccd_pkg::S_IDLE);
	endproperty
	a_call2: assert property (p_call2)
		else $error("call did not last two instruction cycles");

	property p_complement_file_op;
		(do_op && op_reg == ccd_pkg::OP_COMPLEMENT_FILE_OP && d_reg) |=>
			(file_mem[$past(f_reg)] == ~$past(f_val)) && (z_reg == ($past(f_val) == 8'hFF));
	endproperty
	a_complement_file_op: assert property (p_complement_file_op)
		else $error("complement result or zero flag wrong");

	property p_decrement_file_op_w;
		(do_op && op_reg == ccd_pkg::OP_DECREMENT_FILE_OP && !d_reg) |=>
			(w_reg == $past(f_val) - 8'h01) && (file_mem[$past(f_reg)] == $past(f_val));
	endproperty
	a_decrement_file_op_w: assert property (p_decrement_file_op_w)
		else $error("decrement to w routed wrong");

	property p_clear_file_op;
		(do_op && op_reg == ccd_pkg::OP_CLEAR_FILE_OP) |=> z_reg && (file_mem[$past(f_reg)] == 8'h00);
	endproperty
	a_clear_file_op: assert property (p_clear_file_op)
		else $error("clear file failed");

	property p_clear_working_reg_op;
		(do_op && op_reg == ccd_pkg::OP_CLEAR_WORKING_REG_OP) |=> z_reg && (w_reg == 8'h00);
	endproperty
	a_clear_working_reg_op: assert property (p_clear_working_reg_op)
		else $error("clear w failed");

	property p_dsz;
		(do_op && op_reg == ccd_pkg::OP_DECREMENT_SKIP_ON_ZERO_OP) |=>
			(z_reg == $past(z_reg)) && (to_n_reg || $past(wd_bus.timeout))
			&& (skip_reg == ($past(f_val) == 8'h01));
	endproperty
	a_dsz: assert property (p_dsz)
		else $error("decrement skip flags or skip decision wrong");

	property p_skip;
		(exec_go && skip_reg) |=>
			!skip_reg && (pc_reg == $past(pc_reg) + 15'h0001) && $stable(w_reg) && $stable(z_reg);
	endproperty
	a_skip: assert property (p_skip)
		else $error("skipped instruction was not replaced by a no-operation");
endmodule

// file: test/tb_top.sv
// tb_top: self-checking bench for ccd_core, driving its apb port directly
// assumes the register map and op encoding of ccd_pkg and a 4-clock instruction cycle
`timescale 1ns/1ps
module tb_top;
	logic        mclk_i;
	logic        nrst_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic [31:0] rdata;
	logic        perr;
	int          nwait;
	int          num_errors;
	int          checked;
	int          cycles;

	ccd_core DUT (
		.mclk_i    (mclk_i),
		.nrst_i    (nrst_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o)
	);

	// 100 MHz core clock
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// hang guard: the whole run needs well under 20000 clocks
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		nwait = 0;
		// pready is combinational: judge it settled before the edge that takes it,
		// so a busy flag that drops at that same edge cannot fool the master
		@(negedge mclk_i);
		while (pready_o !== 1'b1 && nwait < 200) begin
			nwait++;
			@(negedge mclk_i);
		end
		perr = pslverr_o;
		@(posedge mclk_i);
		rdata = prdata_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// issue an op and poll busy; a stuck busy ends in a mismatch
	task automatic run_op(input logic [2:0] op, input logic d, input logic [6:0] f);
		int n;
		wr(ccd_pkg::OFF_OPCODE, {21'h0, f, d, op});
		n = 0;
		do begin
			rd(ccd_pkg::OFF_STATUS);
			n++;
		end while (rdata[ccd_pkg::STS_BUSY] !== 1'b0 && n < 50);
		check("busy", {31'h0, rdata[ccd_pkg::STS_BUSY]}, 32'h0000_0000);
	endtask

	task automatic setf(input logic [6:0] f, input logic [7:0] v);
		wr(ccd_pkg::OFF_FADDR, {25'h0, f});
		wr(ccd_pkg::OFF_FDATA, {24'h0, v});
	endtask

	task automatic readf(input logic [6:0] f);
		wr(ccd_pkg::OFF_FADDR, {25'h0, f});
		rd(ccd_pkg::OFF_FDATA);
	endtask

	task automatic zflag(input logic exp);
		rd(ccd_pkg::OFF_STATUS);
		check("zero", {31'h0, rdata[ccd_pkg::STS_Z]}, {31'h0, exp});
	endtask

	task automatic t_reset_map();
		rd(ccd_pkg::OFF_STATUS);
		check("status rst", rdata, 32'h0000_0006);
		rd(ccd_pkg::OFF_WREG);
		check("w rst", rdata, 32'h0000_0000);
		rd(8'h24);
		check("unmapped err", {31'h0, perr}, 32'h0000_0001);
		check("unmapped data", rdata, 32'h0000_0000);
	endtask

	// counter wraps after 256 x 4 instruction cycles of 4 clocks
	task automatic t_watchdog();
		repeat (4200) @(posedge mclk_i);
		rd(ccd_pkg::OFF_STATUS);
		check("timed out", {30'h0, rdata[2:1]}, 32'h0000_0002);
		run_op(ccd_pkg::OP_WDCLR, 1'b0, 7'h00);
		rd(ccd_pkg::OFF_STATUS);
		check("flags set", {30'h0, rdata[2:1]}, 32'h0000_0003);
		rd(ccd_pkg::OFF_WDOG);
		check("wdog count", {24'h0, rdata[7:0]}, 32'h0000_0000);
		// a few clocks pass before the read, so the prescaler may have moved by up to two
		check("prescale", {31'h0, rdata[15:8] < 8'h03}, 32'h0000_0001);
	endtask

	task automatic t_clear_ops();
		setf(7'h05, 8'hA5);
		run_op(ccd_pkg::OP_CLEAR_FILE_OP, 1'b1, 7'h05);
		readf(7'h05);
		check("clear_file_op file", rdata, 32'h0000_0000);
		zflag(1'b1);
		wr(ccd_pkg::OFF_WREG, 32'h0000_0033);
		run_op(ccd_pkg::OP_COMPLEMENT_FILE_OP, 1'b0, 7'h05);
		zflag(1'b0);
		run_op(ccd_pkg::OP_CLEAR_WORKING_REG_OP, 1'b0, 7'h00);
		rd(ccd_pkg::OFF_WREG);
		check("clear_working_reg_op w", rdata, 32'h0000_0000);
		zflag(1'b1);
	endtask

	task automatic t_comp_dec();
		setf(7'h07, 8'h0F);
		run_op(ccd_pkg::OP_COMPLEMENT_FILE_OP, 1'b0, 7'h07);
		rd(ccd_pkg::OFF_WREG);
		check("complement_file_op to w", rdata, 32'h0000_00F0);
		readf(7'h07);
		check("complement_file_op file kept", rdata, 32'h0000_000F);
		zflag(1'b0);
		setf(7'h08, 8'hFF);
		run_op(ccd_pkg::OP_COMPLEMENT_FILE_OP, 1'b1, 7'h08);
		readf(7'h08);
		check("complement_file_op to file", rdata, 32'h0000_0000);
		zflag(1'b1);
		setf(7'h09, 8'h01);
		run_op(ccd_pkg::OP_DECREMENT_FILE_OP, 1'b1, 7'h09);
		readf(7'h09);
		check("decrement_file_op to file", rdata, 32'h0000_0000);
		zflag(1'b1);
		run_op(ccd_pkg::OP_DECREMENT_FILE_OP, 1'b0, 7'h09);
		rd(ccd_pkg::OFF_WREG);
		check("decrement_file_op wrap to w", rdata, 32'h0000_00FF);
		zflag(1'b0);
	endtask

	task automatic t_skip();
		run_op(ccd_pkg::OP_CLEAR_WORKING_REG_OP, 1'b0, 7'h00);
		setf(7'h0A, 8'h02);
		run_op(ccd_pkg::OP_DECREMENT_SKIP_ON_ZERO_OP, 1'b1, 7'h0A);
		readf(7'h0A);
		check("dsz to file", rdata, 32'h0000_0001);
		zflag(1'b1);
		check("no skip", {31'h0, rdata[ccd_pkg::STS_SKIP]}, 32'h0000_0000);
		wr(ccd_pkg::OFF_WREG, 32'h0000_0055);
		run_op(ccd_pkg::OP_CLEAR_WORKING_REG_OP, 1'b0, 7'h00);
		rd(ccd_pkg::OFF_WREG);
		check("next runs", rdata, 32'h0000_0000);
		setf(7'h0B, 8'h00);
		run_op(ccd_pkg::OP_COMPLEMENT_FILE_OP, 1'b1, 7'h0B);
		setf(7'h0C, 8'h01);
		wr(ccd_pkg::OFF_PC, 32'h0000_0040);
		run_op(ccd_pkg::OP_DECREMENT_SKIP_ON_ZERO_OP, 1'b0, 7'h0C);
		rd(ccd_pkg::OFF_WREG);
		check("dsz to w", rdata, 32'h0000_0000);
		zflag(1'b0);
		check("skip set", {31'h0, rdata[ccd_pkg::STS_SKIP]}, 32'h0000_0001);
		wr(ccd_pkg::OFF_WREG, 32'h0000_0055);
		run_op(ccd_pkg::OP_CLEAR_WORKING_REG_OP, 1'b0, 7'h00);
		rd(ccd_pkg::OFF_WREG);
		check("skipped op", rdata, 32'h0000_0055);
		zflag(1'b0);
		check("skip used", {31'h0, rdata[ccd_pkg::STS_SKIP]}, 32'h0000_0000);
		rd(ccd_pkg::OFF_PC);
		check("pc after skip", rdata, 32'h0000_0042);
	endtask

	task automatic t_call();
		run_op(ccd_pkg::OP_CLEAR_WORKING_REG_OP, 1'b0, 7'h00);
		wr(ccd_pkg::OFF_PCLAT, 32'h0000_0012);
		wr(ccd_pkg::OFF_WREG, 32'h0000_0034);
		wr(ccd_pkg::OFF_PC, 32'h0000_0200);
		run_op(ccd_pkg::OP_CALL_VIA_WORKING_REG_OP, 1'b0, 7'h00);
		rd(ccd_pkg::OFF_PC);
		check("call pc", rdata, 32'h0000_1234);
		rd(ccd_pkg::OFF_TOS);
		check("call tos", rdata, 32'h0001_0201);
		zflag(1'b1);
	endtask

	// stall seen by a third write after two back-to-back ops
	task automatic stall_after(input logic [2:0] op, output int w);
		wr(ccd_pkg::OFF_OPCODE, 32'h0000_0000);
		wr(ccd_pkg::OFF_OPCODE, {29'h0, op});
		wr(ccd_pkg::OFF_OPCODE, 32'h0000_0000);
		w = nwait;
		run_op(ccd_pkg::OP_NOP, 1'b0, 7'h00);
	endtask

	task automatic t_cycles();
		int w_nop;
		int w_call;
		stall_after(ccd_pkg::OP_NOP, w_nop);
		stall_after(ccd_pkg::OP_CALL_VIA_WORKING_REG_OP, w_call);
		check("call extra cycle", w_call, w_nop + 4);
	endtask

	initial begin
		nrst_i     = 1'b0;
		psel_i     = 1'b0;
		penable_i  = 1'b0;
		pwrite_i   = 1'b0;
		paddr_i    = 8'h00;
		pwdata_i   = 32'h0000_0000;
		num_errors = 0;
		checked    = 0;
		cycles     = 0;
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_reset_map();
		t_watchdog();
		t_clear_ops();
		t_comp_dec();
		t_skip();
		t_call();
		t_cycles();
		report_and_stop();
	end
endmodule
